// file: dv/watchdog_reset_control_tb_top.sv
// Self-checking bench of the watchdog supervision block
`timescale 1ns/1ns
`default_nettype none
`include "watchdog_reset_control_defines.svh"

module watchdog_reset_control_tb_top;
    // Short exponents keep each time-out run to a few hundred cycles
    localparam int EXP0 = 4;
    localparam int EXP1 = 5;
    localparam int EXP2 = 6;
    localparam int EXP3 = 7;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic extResetPin = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, irq, wdResetOut;
    logic wdHi, wdTop, pwHi, pwTop, boHi, boTop;
    int badCount = 0;
    int checksDone = 0;
    int resetPulses = 0;
    int exps[4] = '{EXP0, EXP1, EXP2, EXP3};
    int span, n;
    logic [32:0] expQ[$];
    logic [7:0] ext, top;
    logic [1:0] sel;

    always #5 clk = ~clk;

    watchdog_reset_control #(.TOUT_EXP0(EXP0), .TOUT_EXP1(EXP1),
        .TOUT_EXP2(EXP2), .TOUT_EXP3(EXP3)) i_dut (
        .clk(clk),
        .rst(rst),
        .extResetPin(extResetPin),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .irq(irq),
        .wdResetOut(wdResetOut),
        .wdPrioHigher(wdHi),
        .wdPrioHighest(wdTop),
        .pulsePrioHigher(pwHi),
        .pulsePrioHighest(pwTop),
        .brownoutPrioHigher(boHi),
        .brownoutPrioHighest(boTop)
    );

    task automatic completeRun();
        $display("checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        checksDone++;
        if (seen !== want) begin
            badCount++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, want);
        end
    endtask

    // Request held until pready is sampled high, released just after
    task automatic apb(input logic wr, input logic [7:0] idx,
        input logic [7:0] data);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, data};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1)
            check(33'h000000000, 33'h000000001);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] data);
        apb(1'b1, idx, data);
    endtask

    task automatic rd(input logic [7:0] idx, input logic err,
        input logic [7:0] data);
        expQ.push_back({err, 24'h000000, data});
        apb(1'b0, idx, 8'h00);
    endtask

    task automatic unlock();
        wr(`WD_IDX_KEY, `WD_KEY_FIRST);
        wr(`WD_IDX_KEY, `WD_KEY_SECOND);
    endtask

    task automatic irqIs(input logic v);
        repeat (2) @(posedge clk);
        check({32'h00000000, irq}, {32'h00000000, v});
    endtask

    // Read results are judged here, in order of request
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite) begin
            if (expQ.size() == 0)
                check(33'h1FFFFFFFF, 33'h000000000);
            else
                check({pslverr, prdata}, expQ.pop_front());
        end
        if (wdResetOut === 1'b1)
            resetPulses++;
    end

    initial begin
        repeat (20000) @(posedge clk);
        badCount++;
        completeRun();
    end

    initial begin
        ext = 8'($urandom(32'h2D70));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(`WD_IDX_CTRL, 1'b0, `WD_CTRL_RESET);
        rd(`WD_IDX_PRIO_TOP, 1'b0, 8'h00);
        rd(`WD_IDX_KEY, 1'b0, 8'h00);
        rd(8'h10, 1'b1, 8'h00);
        wr(`WD_IDX_CTRL, 8'hFF);
        rd(`WD_IDX_CTRL, 1'b0, 8'h74);
        irqIs(1'b0);
        wr(`WD_IDX_IRQ_MASK, 8'h03);
        irqIs(1'b1);
        rd(`WD_IDX_IRQ_STAT, 1'b0, 8'h02);
        wr(`WD_IDX_IRQ_STAT, 8'h02);
        irqIs(1'b0);
        unlock();
        wr(`WD_IDX_CTRL, 8'h01);
        rd(`WD_IDX_CTRL, 1'b0, 8'h00);
        irqIs(1'b0);
        // Window must have shut well before this write
        unlock();
        repeat (16) @(posedge clk);
        wr(`WD_IDX_CTRL, 8'h80);
        rd(`WD_IDX_CTRL, 1'b0, 8'h00);
        wr(`WD_IDX_KEY, `WD_KEY_FIRST);
        repeat (16) @(posedge clk);
        wr(`WD_IDX_KEY, `WD_KEY_SECOND);
        wr(`WD_IDX_CTRL, 8'h80);
        rd(`WD_IDX_CTRL, 1'b0, 8'h00);
        wr(`WD_IDX_IRQ_STAT, 8'h03);
        top = 8'($urandom);
        wr(`WD_IDX_PRIO_EXT, ext);
        wr(`WD_IDX_PRIO_TOP, top);
        rd(`WD_IDX_PRIO_EXT, 1'b0, ext & `WD_PRIO_MASK);
        rd(`WD_IDX_PRIO_TOP, 1'b0, top & `WD_PRIO_MASK);
        check({27'h0, boTop, pwTop, wdTop, boHi, pwHi, wdHi},
            {27'h0, top[6:4], ext[6:4]});
        for (int s = 0; s < 4; s++) begin
            sel = 2'(s);
            span = 1 << exps[s];
            unlock();
            wr(`WD_IDX_CTRL, {2'b00, sel, 4'h1});
            wr(`WD_IDX_CTRL, {2'b10, sel, 4'h0});
            repeat (span - 10) @(posedge clk);
            rd(`WD_IDX_CTRL, 1'b0, {2'b10, sel, 4'h0});
            repeat (20) @(posedge clk);
            rd(`WD_IDX_CTRL, 1'b0, {2'b10, sel, 4'h8});
            irqIs(1'b1);
            wr(`WD_IDX_IRQ_MASK, 8'h00);
            irqIs(1'b0);
            wr(`WD_IDX_IRQ_MASK, 8'h03);
            repeat (600) @(posedge clk);
            check(33'(resetPulses), 33'h000000000);
            unlock();
            wr(`WD_IDX_CTRL, 8'h00);
            wr(`WD_IDX_IRQ_STAT, 8'h01);
            rd(`WD_IDX_CTRL, 1'b0, 8'h00);
            irqIs(1'b0);
        end
        // Time-out with reset enabled, random select
        sel = 2'($urandom);
        span = (1 << exps[sel]) + 512;
        unlock();
        wr(`WD_IDX_CTRL, {2'b00, sel, 4'h1});
        wr(`WD_IDX_CTRL, {2'b10, sel, 4'h2});
        n = 0;
        while (wdResetOut !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        check({32'h0, n >= span - 2 && n <= span + 2}, 33'h1);
        repeat (3) @(posedge clk);
        rd(`WD_IDX_CTRL, 1'b0, 8'h04);
        extResetPin <= 1'b1;
        @(posedge clk);
        extResetPin <= 1'b0;
        repeat (3) @(posedge clk);
        rd(`WD_IDX_CTRL, 1'b0, 8'h04);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(`WD_IDX_CTRL, 1'b0, 8'h00);
        check(33'(resetPulses), 33'h000000001);
        completeRun();
    end
endmodule
`default_nettype wire

// file: pkg/watchdog_reset_control_defines.svh
// Constants of the watchdog supervision block
// Contract
// RULE1: Power-on reset loads the control register with all zero bits.
// RULE2: Watchdog reset sets the reset-cause flag; power resets clear it.
// RULE3: External pin reset leaves the reset-cause flag unchanged.
// RULE4: Every kind of reset clears the watchdog reset-enable bit.
// RULE5: All control register bits are readable at any time.
// RULE6: Run, reset-enable, time-out flag, restart bits only written inside window.
// RULE7: Software writes AAh then 55h to the key register first.
// RULE8: Select bits both one choose the longest period, 26 counter bits.
// RULE9: Extended priority bit 4 raises watchdog interrupt to higher level.
// RULE10: Top priority bit 4 raises watchdog interrupt to highest level.
// RULE11: Bit 5 of both priority registers holds PWM underflow priority.
// RULE12: Bit 6 of both priority registers holds brown-out priority.
// RULE13: Select bits pick 2^17..2^26 clocks; reset follows 512 clocks later.
// RULE14: Each elapsed time-out sets the time-out flag, cleared by software.
// RULE15: With reset disabled a time-out neither resets nor touches cause flag.
// RULE16: A valid key opens the protected window for 3 machine cycles.
// RULE17: Writing one to restart clears the count; the bit self-clears.
`ifndef WATCHDOG_RESET_CONTROL_DEFINES_SVH
`define WATCHDOG_RESET_CONTROL_DEFINES_SVH

`define WD_IDX_KEY 8'hC7
`define WD_IDX_CTRL 8'hD8
`define WD_IDX_IRQ_STAT 8'hE0
`define WD_IDX_IRQ_MASK 8'hE1
`define WD_IDX_PRIO_TOP 8'hF7
`define WD_IDX_PRIO_EXT 8'hF8

`define WD_BIT_RUN 7
`define WD_BIT_SEL_HI 5
`define WD_BIT_SEL_LO 4
`define WD_BIT_TOF 3
`define WD_BIT_CAUSE 2
`define WD_BIT_RSTEN 1
`define WD_BIT_RESTART 0
`define WD_CTRL_RESET 8'h00
`define WD_CTRL_PROT 8'h8B
`define WD_PRIO_MASK 8'h70
`define WD_PRIO_WD 4
`define WD_PRIO_PWM 5
`define WD_PRIO_BOV 6

`define WD_KEY_FIRST 8'hAA
`define WD_KEY_SECOND 8'h55

`define WD_IRQ_TIMEOUT 0
`define WD_IRQ_DENIED 1
`define WD_IRQ_MASK 8'h03

`define WD_EXP0 17
`define WD_EXP1 20
`define WD_EXP2 23
`define WD_EXP3 26
`define WD_RESET_EXTRA 27'h200

`define WD_CLK_MHZ 100
`define WD_MC_CLKS 4
`define WD_TA_MC 3
`define WD_TA_CLKS (`WD_TA_MC * `WD_MC_CLKS)

`endif

// file: pkg/watchdog_reset_control_pkg.sv
// Types of the watchdog supervision block
package watchdog_reset_control_pkg;
    typedef enum logic [1:0] {
        TA_IDLE,
        TA_ARMED,
        TA_OPEN
    } ta_state_t;
endpackage

// file: verilog/watchdog_reset_control.sv
// Watchdog timer with timed-access protection and APB register slave
`timescale 1ns/1ns
`default_nettype none
`include "watchdog_reset_control_defines.svh"

module watchdog_reset_control #(
    parameter int TOUT_EXP0 = `WD_EXP0,
    parameter int TOUT_EXP1 = `WD_EXP1,
    parameter int TOUT_EXP2 = `WD_EXP2,
    parameter int TOUT_EXP3 = `WD_EXP3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic extResetPin,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic wdResetOut,
    output logic wdPrioHigher,
    output logic wdPrioHighest,
    output logic pulsePrioHigher,
    output logic pulsePrioHighest,
    output logic brownoutPrioHigher,
    output logic brownoutPrioHighest
);

    localparam logic [3:0] TA_LAST = 4'(`WD_TA_CLKS - 1);

    logic [7:0] ctrlReg, ctrlNext;
    logic [7:0] prioTopReg, prioTopNext;
    logic [7:0] prioExtReg, prioExtNext;
    logic [7:0] statReg, statNext;
    logic [7:0] maskReg, maskNext;
    logic [26:0] cntReg, cntNext;
    logic [3:0] taTmrReg, taTmrNext;
    watchdog_reset_control_pkg::ta_state_t taReg, taNext;
    logic [31:0] prdataReg, prdataNext;
    logic preadyReg, preadyNext;
    logic slverrReg, slverrNext;
    logic irqReg, irqNext;
    logic wdRstReg, wdRstNext;

    logic [7:0] idx;
    logic mapped, wrDone, rdCapture;
    logic wrCtrl, wrKey, windowOpen;
    logic [4:0] expSel;
    logic [26:0] periodVal, tickPoint, resetPoint;
    logic running, tickEvt, resetEvt, deniedEvt, sysInit;

    assign idx = paddr[9:2];
    assign mapped = idx == `WD_IDX_CTRL || idx == `WD_IDX_KEY ||
        idx == `WD_IDX_PRIO_TOP || idx == `WD_IDX_PRIO_EXT ||
        idx == `WD_IDX_IRQ_STAT || idx == `WD_IDX_IRQ_MASK;
    // One wait state so read data can come from a flop
    assign rdCapture = psel && penable && !preadyReg;
    assign wrDone = psel && penable && preadyReg && pwrite && mapped;
    assign wrCtrl = wrDone && idx == `WD_IDX_CTRL;
    assign wrKey = wrDone && idx == `WD_IDX_KEY;
    assign windowOpen = taReg == watchdog_reset_control_pkg::TA_OPEN;
    // Watchdog reset acts like a chip reset one cycle after the event
    assign sysInit = extResetPin || wdRstReg;

    always_comb begin
        unique case (ctrlReg[`WD_BIT_SEL_HI:`WD_BIT_SEL_LO])
            2'b00: expSel = 5'(TOUT_EXP0);
            2'b01: expSel = 5'(TOUT_EXP1);
            2'b10: expSel = 5'(TOUT_EXP2);
            2'b11: expSel = 5'(TOUT_EXP3); // see RULE8
        endcase
    end

    assign periodVal = 27'h1 << expSel;
    assign tickPoint = periodVal - 27'h1;
    assign resetPoint = periodVal + `WD_RESET_EXTRA - 27'h1; // see RULE13
    assign running = ctrlReg[`WD_BIT_RUN];
    assign tickEvt = running && cntReg == tickPoint;
    assign resetEvt = running && cntReg == resetPoint;

    // Counter
    always_comb begin
        cntNext = cntReg;
        if (sysInit || ctrlReg[`WD_BIT_RESTART]) begin
            cntNext = 27'h0; // see RULE17
        end else if (running) begin
            cntNext = resetEvt ? 27'h0 : cntReg + 27'h1;
        end
        // Reset only when enabled; otherwise the count just wraps
        wdRstNext = !sysInit && resetEvt && ctrlReg[`WD_BIT_RSTEN]; // see RULE15
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cntReg <= 27'h0;
            wdRstReg <= 1'b0;
        end else begin
            cntReg <= cntNext;
            wdRstReg <= wdRstNext;
        end
    end

    // Timed-access key sequence
    always_comb begin
        taNext = taReg;
        taTmrNext = taTmrReg;
        if (sysInit) begin
            taNext = watchdog_reset_control_pkg::TA_IDLE;
            taTmrNext = 4'h0;
        end else if (wrKey && pwdata[7:0] == `WD_KEY_FIRST) begin
            taNext = watchdog_reset_control_pkg::TA_ARMED; // see RULE7
            taTmrNext = TA_LAST;
        end else if (wrKey && taReg == watchdog_reset_control_pkg::TA_ARMED
                && pwdata[7:0] == `WD_KEY_SECOND) begin
            taNext = watchdog_reset_control_pkg::TA_OPEN; // see RULE16
            taTmrNext = TA_LAST;
        end else if (wrKey) begin
            taNext = watchdog_reset_control_pkg::TA_IDLE;
            taTmrNext = 4'h0;
        end else if (taReg != watchdog_reset_control_pkg::TA_IDLE) begin
            if (taTmrReg == 4'h0) begin
                taNext = watchdog_reset_control_pkg::TA_IDLE; // see RULE16
            end else begin
                taTmrNext = taTmrReg - 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            taReg <= watchdog_reset_control_pkg::TA_IDLE;
            taTmrReg <= 4'h0;
        end else begin
            taReg <= taNext;
            taTmrReg <= taTmrNext;
        end
    end

    // Registers
    always_comb begin
        ctrlNext = ctrlReg;
        prioTopNext = prioTopReg;
        prioExtNext = prioExtReg;
        statNext = statReg;
        maskNext = maskReg;
        deniedEvt = wrCtrl && !windowOpen &&
            ((pwdata[7:0] ^ ctrlReg) & `WD_CTRL_PROT) != 8'h00;
        ctrlNext[`WD_BIT_RESTART] = 1'b0; // see RULE17
        if (wrCtrl) begin
            ctrlNext = (ctrlReg & `WD_CTRL_PROT) |
                (pwdata[7:0] & ~`WD_CTRL_PROT); // see RULE6
            if (windowOpen) begin
                ctrlNext = pwdata[7:0]; // see RULE6
            end
        end
        if (tickEvt) begin
            ctrlNext[`WD_BIT_TOF] = 1'b1; // see RULE14
        end
        if (wrDone && idx == `WD_IDX_PRIO_TOP) begin
            prioTopNext = pwdata[7:0] & `WD_PRIO_MASK; // see RULE10
        end
        if (wrDone && idx == `WD_IDX_PRIO_EXT) begin
            prioExtNext = pwdata[7:0] & `WD_PRIO_MASK; // see RULE9
        end
        if (wrDone && idx == `WD_IDX_IRQ_MASK) begin
            maskNext = pwdata[7:0] & `WD_IRQ_MASK;
        end
        if (wrDone && idx == `WD_IDX_IRQ_STAT) begin
            statNext = statReg & ~pwdata[7:0];
        end
        // Set wins over a same-cycle clear
        statNext[`WD_IRQ_TIMEOUT] = statNext[`WD_IRQ_TIMEOUT] | tickEvt;
        statNext[`WD_IRQ_DENIED] = statNext[`WD_IRQ_DENIED] | deniedEvt;
        if (sysInit) begin
            ctrlNext = `WD_CTRL_RESET; // see RULE4
            prioTopNext = 8'h00;
            prioExtNext = 8'h00;
            statNext = 8'h00;
            maskNext = 8'h00;
            // Pin reset keeps cause, watchdog reset sets it
            ctrlNext[`WD_BIT_CAUSE] = wdRstReg || ctrlReg[`WD_BIT_CAUSE]; // see RULE2 RULE3
        end
        irqNext = (statNext & maskNext) != 8'h00;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrlReg <= `WD_CTRL_RESET; // see RULE1 RULE2
            prioTopReg <= 8'h00;
            prioExtReg <= 8'h00;
            statReg <= 8'h00;
            maskReg <= 8'h00;
            irqReg <= 1'b0;
        end else begin
            ctrlReg <= ctrlNext;
            prioTopReg <= prioTopNext;
            prioExtReg <= prioExtNext;
            statReg <= statNext;
            maskReg <= maskNext;
            irqReg <= irqNext;
        end
    end

    // APB answer
    always_comb begin
        prdataNext = prdataReg;
        slverrNext = slverrReg;
        preadyNext = rdCapture;
        if (rdCapture) begin
            slverrNext = !mapped;
            prdataNext = 32'h0;
            if (!pwrite) begin
                unique case (idx)
                    `WD_IDX_CTRL: prdataNext = {24'h0, ctrlReg}; // see RULE5
                    `WD_IDX_PRIO_TOP: prdataNext = {24'h0, prioTopReg};
                    `WD_IDX_PRIO_EXT: prdataNext = {24'h0, prioExtReg};
                    `WD_IDX_IRQ_STAT: prdataNext = {24'h0, statReg};
                    `WD_IDX_IRQ_MASK: prdataNext = {24'h0, maskReg};
                    default: prdataNext = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdataReg <= 32'h0;
            preadyReg <= 1'b0;
            slverrReg <= 1'b0;
        end else begin
            prdataReg <= prdataNext;
            preadyReg <= preadyNext;
            slverrReg <= slverrNext;
        end
    end

    assign prdata = prdataReg;
    assign pready = preadyReg;
    assign pslverr = slverrReg;
    assign irq = irqReg;
    assign wdResetOut = wdRstReg;
    assign wdPrioHigher = prioExtReg[`WD_PRIO_WD]; // see RULE9
    assign wdPrioHighest = prioTopReg[`WD_PRIO_WD]; // see RULE10
    assign pulsePrioHigher = prioExtReg[`WD_PRIO_PWM]; // see RULE11
    assign pulsePrioHighest = prioTopReg[`WD_PRIO_PWM]; // see RULE11
    assign brownoutPrioHigher = prioExtReg[`WD_PRIO_BOV]; // see RULE12
    assign brownoutPrioHighest = prioTopReg[`WD_PRIO_BOV]; // see RULE12

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence keyOpenSeq;
        wrKey && pwdata[7:0] == `WD_KEY_SECOND &&
            taReg == watchdog_reset_control_pkg::TA_ARMED && !sysInit;
    endsequence

    a_por_ctrl_value: assert property (disable iff (1'b0) // see RULE1
        $past(rst) |-> ctrlReg == `WD_CTRL_RESET)
        else $error("Control register not zero after power-on reset");
    a_wd_cause_set: assert property ( // see RULE2
        wdRstReg && !rst |=> ctrlReg[`WD_BIT_CAUSE] && !ctrlReg[`WD_BIT_RSTEN])
        else $error("Watchdog reset did not set cause flag");
    a_pin_keeps_cause: assert property ( // see RULE3
        extResetPin && !wdRstReg |=> !ctrlReg[`WD_BIT_RSTEN] &&
            ctrlReg[`WD_BIT_CAUSE] == $past(ctrlReg[`WD_BIT_CAUSE]))
        else $error("Pin reset changed cause flag");
    a_prot_blocked: assert property ( // see RULE6
        wrCtrl && !windowOpen && !sysInit |=>
            $stable(ctrlReg[`WD_BIT_RUN]) && $stable(ctrlReg[`WD_BIT_RSTEN]))
        else $error("Protected bit written outside window");
    a_free_write: assert property ( // see RULE6
        wrCtrl && !sysInit |=> ctrlReg[`WD_BIT_SEL_HI:`WD_BIT_SEL_LO] ==
            $past(pwdata[`WD_BIT_SEL_HI:`WD_BIT_SEL_LO]))
        else $error("Select bits not written freely");
    a_window_len: assert property ( // see RULE16
        keyOpenSeq ##1 !wrKey [*8] ##1 !wrKey [*4] |-> ##1 !windowOpen)
        else $error("Window length wrong");
    a_window_open: assert property ( // see RULE16
        keyOpenSeq |=> windowOpen [*8])
        else $error("Window closed too early");
    a_timeout_flag: assert property ( // see RULE14
        tickEvt && !sysInit |=> ctrlReg[`WD_BIT_TOF] ##1 1'b1)
        else $error("Time-out flag not set");
    a_reset_point: assert property ( // see RULE13 RULE15
        resetEvt && !sysInit |=> wdRstReg == $past(ctrlReg[`WD_BIT_RSTEN]))
        else $error("Watchdog reset decision wrong");
    a_restart_clears: assert property ( // see RULE17
        ctrlReg[`WD_BIT_RESTART] |=> cntReg == 27'h0 &&
            !ctrlReg[`WD_BIT_RESTART])
        else $error("Restart did not clear count");
    a_prio_write: assert property ( // see RULE9
        wrDone && idx == `WD_IDX_PRIO_EXT && !sysInit |=>
            wdPrioHigher == $past(pwdata[`WD_PRIO_WD]))
        else $error("Priority bit not written");
    a_irq_level: assert property (
        (statReg & maskReg) != 8'h00 |-> irq)
        else $error("Interrupt low with unmasked status");

endmodule
`default_nettype wire
